// ==== rtl/sbc_wake_pkg.sv ====
// Package with constants, mode codes and helpers of the stop-mode wake logic.
`default_nettype none

package sbc_wake_pkg;
    // Clock and bus geometry.
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    // Register byte addresses; configuration set i sits at CFG_BASE plus four times i.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG_BASE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Control word layout.
    localparam int BIT_MS0 = 0;
    localparam int BIT_CS0 = 3;
    localparam int CFG_LSB = 5;
    localparam int CFG_W = 9;
    localparam int BIT_MEAS_ON = 14;
    localparam int BIT_WD_KEEP = 15;
    // Configuration sets selected by the two selection bits.
    localparam logic [1:0] CFG_GENERAL = 2'h0;
    localparam logic [1:0] CFG_CYCLIC = 2'h2;
    // Field positions inside the general set, counted from CFG_LSB.
    localparam int GEN_SLOW = 2;
    localparam int GEN_MON_LSB = 3;
    localparam int MON_N = 5;
    localparam int GEN_MEAS_CH = 8;
    // Reset values.
    localparam logic [8:0] CFG_RST = 9'h000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // Internal oscillator cycle, rounded up to whole clocks.
    localparam int INT_CYCLE_NS = 1000;
    localparam int INT_CYCLE_CLKS = (INT_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_TICKS = 2;
    // Transmit dominant timeout and recovery time.
    localparam int TXD_TO_US = 12000;
    localparam int TXD_TO_CLKS = TXD_TO_US * CLK_MHZ;
    localparam int TXD_REC_US = 10;
    localparam int TXD_REC_CLKS = TXD_REC_US * CLK_MHZ;
    // Bus rate limits in normal and reduced-slope operation.
    localparam int BAUD_NORMAL = 20000;
    localparam int BAUD_SLOW = 10400;

    typedef enum logic [2:0] {
        M_STANDBY = 3'h0,
        M_ACT_BUS_SLEEP = 3'h2,
        M_ACTIVE = 3'h3,
        M_SLEEP = 3'h4,
        M_RX_ONLY = 3'h6,
        M_STOP = 3'h7
    } mode_t;

    // True for codes that software may select.
    function automatic logic mode_selectable(input logic [2:0] c);
        return (c == 3'h2) || (c == 3'h3) || (c == 3'h4) || (c == 3'h6) || (c == 3'h7);
    endfunction

    // True for the two power-saving modes.
    function automatic logic is_saving(input mode_t m);
        return (m == M_STOP) || (m == M_SLEEP);
    endfunction
endpackage
`default_nettype wire

// ==== rtl/wake_timer_if.sv ====
// Interface between the mode logic and the cyclic wake timer.
`default_nettype none

interface wake_timer_if;
    logic run;
    logic [8:0] period;
    logic pulse;
    modport ctrl(output run, output period, input pulse);
    modport timer(input run, input period, output pulse);
endinterface
`default_nettype wire

// ==== rtl/cyclic_wake_timer.sv ====
// Cyclic wake timer that emits a two internal cycle pulse every period.
`default_nettype none

module cyclic_wake_timer
    import sbc_wake_pkg::*;
#(
    parameter int CYCLE_CLKS = INT_CYCLE_CLKS
) (
    input wire logic clock,
    input wire logic rst,
    wake_timer_if.timer tif
);
    logic [15:0] pre_q;
    logic [8:0] per_q;
    logic [1:0] pls_q;
    wire tick = (pre_q == 16'(CYCLE_CLKS - 1));
    wire wrap = (per_q >= 9'(tif.period - 9'h1));

    // Prescaler, period counter and pulse length counter, all cleared while not running.
    always_ff @(posedge clock) begin
        if (rst || !tif.run) begin
            pre_q <= 16'h0000;
            per_q <= 9'h000;
            pls_q <= 2'h0;
        end else begin
            pre_q <= tick ? 16'h0000 : 16'(pre_q + 16'h0001);
            if (tick && wrap) begin
                per_q <= 9'h000;
                pls_q <= 2'(PULSE_TICKS);
            end else if (tick) begin
                per_q <= 9'(per_q + 9'h001);
                pls_q <= (pls_q != 2'h0) ? 2'(pls_q - 2'h1) : 2'h0;
            end
        end
    end

    assign tif.pulse = (pls_q != 2'h0);
endmodule // cyclic_wake_timer
`default_nettype wire

// ==== rtl/txd_dominant_guard.sv ====
// Transmit dominant timeout guard with recovery after a high period.
`default_nettype none

module txd_dominant_guard #(
    parameter int TO_CLKS = 1200000,
    parameter int REC_CLKS = 1000,
    parameter int CW = 24
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic txd_in,
    output logic blocked
);
    logic [CW-1:0] cnt_q;
    wire to_hit = (cnt_q == CW'(TO_CLKS - 1));
    wire rec_hit = (cnt_q == CW'(REC_CLKS - 1));

    // Counts low cycles while free, high cycles while blocked.
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
            blocked <= 1'b0;
        end else if (!blocked) begin
            if (txd_in) begin
                cnt_q <= '0;
            end else if (to_hit) begin
                cnt_q <= '0;
                blocked <= 1'b1;
            end else begin
                cnt_q <= CW'(cnt_q + 1'b1);
            end
        end else begin
            if (!txd_in) begin
                cnt_q <= '0;
            end else if (rec_hit) begin
                cnt_q <= '0;
                blocked <= 1'b0;
            end else begin
                cnt_q <= CW'(cnt_q + 1'b1);
            end
        end
    end
endmodule // txd_dominant_guard
`default_nettype wire

// ==== rtl/stop_mode_wake_signalling.sv ====
// Mode control, wake signalling, watchdog gating and transmit path of the basis chip.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none

module stop_mode_wake_signalling
    import sbc_wake_pkg::*;
#(
    parameter int CYCLE_CLKS = INT_CYCLE_CLKS,
    parameter int TO_CLKS = TXD_TO_CLKS,
    parameter int REC_CLKS = TXD_REC_CLKS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire logic bus_wake,
    input wire logic [MON_N-1:0] monitor_wake_inputs,
    input wire logic ldo_load_low,
    input wire logic txd_in,
    input wire logic bus_rx_in,
    output logic serial_dout,
    output logic rxd_out,
    output logic bus_tx_out,
    output logic transceiver_en,
    output logic termination_en,
    output logic core_supply_regulator_en,
    output logic slow_slope_en,
    output logic meas_en,
    output logic meas_channel_sel,
    output logic converter_reference_output,
    output logic watchdog_en,
    output logic watchdog_long_open
);
    // Notification length in clocks: two internal cycles.
    localparam logic [15:0] NOTE_CLKS = 16'(PULSE_TICKS * CYCLE_CLKS);

    mode_t mode_q;
    mode_t mode_d;
    logic [CFG_W-1:0] cfg_q [0:3];
    logic meas_on_q;
    logic wd_keep_q;
    logic wd_keep_stop_q;
    logic wd_off_q;
    logic [MON_N-1:0] mon_prev_q;
    logic rxd_low_q;
    logic dout_hold_q;
    logic [15:0] note_cnt_q;
    logic bus_flag_q;
    logic mon_flag_q;
    logic [DATA_W-1:0] rd_mux;
    logic txd_blocked;

    wake_timer_if tif ();

    // Control word fields as seen on a write.
    wire mode_select_bit0 = wdata[BIT_MS0];
    wire mode_select_bit1 = wdata[BIT_MS0+1];
    wire mode_select_bit2 = wdata[BIT_MS0+2];
    wire [2:0] new_code = {mode_select_bit2, mode_select_bit1, mode_select_bit0};
    wire [1:0] cfg_sel = wdata[BIT_CS0+:2];
    wire [CFG_W-1:0] cfg_field = wdata[CFG_LSB+:CFG_W];
    wire watchdog_keep_on_bit = wdata[BIT_WD_KEEP];

    // Address decode of the plain register port.
    wire wr_ctrl = wr_en && (addr == ADDR_CTRL);
    wire code_ok = mode_selectable(new_code);
    wire mode_wr = wr_ctrl && code_ok && (mode_t'(new_code) != mode_q);
    wire enter_saving = mode_wr && is_saving(mode_t'(new_code));

    // Mode qualifiers.
    wire in_stop = (mode_q == M_STOP);
    wire in_sleep = (mode_q == M_SLEEP);
    wire in_active = (mode_q == M_ACTIVE);
    wire in_rx_only = (mode_q == M_RX_ONLY);

    // Configuration fields in use.
    wire [CFG_W-1:0] gen_cfg = cfg_q[CFG_GENERAL];
    wire [CFG_W-1:0] cyc_period = cfg_q[CFG_CYCLIC];
    wire [MON_N-1:0] mon_en = gen_cfg[GEN_MON_LSB+:MON_N];
    wire cyc_on = in_stop && (cyc_period != 9'h000);

    // Wake detection runs every cycle, whatever the cyclic timer phase.
    wire mon_evt = |((monitor_wake_inputs ^ mon_prev_q) & mon_en);
    wire stop_bus_wake = in_stop && bus_wake;
    wire stop_mon_wake = in_stop && mon_evt;
    wire sleep_wake = in_sleep && (bus_wake || mon_evt);
    wire saving_bus_wake = stop_bus_wake || (in_sleep && bus_wake);

    // A stop wake without cyclic wake gives a two internal cycle notification.
    wire note_load = (stop_bus_wake || stop_mon_wake) && !cyc_on;
    // A cyclic stop wake, or a sleep bus wake, holds data-out low until a command.
    wire hold_set = (cyc_on && (stop_bus_wake || stop_mon_wake))
                  || (in_sleep && bus_wake);

    // Automatic exit from sleep takes priority over a command in the same cycle.
    assign mode_d = sleep_wake ? M_STANDBY
                  : mode_wr ? mode_t'(new_code)
                  : mode_q;
    wire leave_saving = is_saving(mode_q) && (mode_d != mode_q);

    // Watchdog switch-off in stop on low regulator load, unless kept on.
    wire wd_off_set = in_stop && ldo_load_low && !wd_keep_stop_q;
    wire wd_stop_off = in_stop && (wd_off_q || wd_off_set);
    wire wd_sleep_off = in_sleep && !wd_keep_stop_q;
    wire wd_on_now = !(wd_stop_off || wd_sleep_off);
    wire long_open_d = leave_saving && (!watchdog_en || cyc_on);

    // Data-out level: low for any pending notification, hold or cyclic pulse.
    wire note_busy = (note_cnt_q != 16'h0000);
    wire dout_low = note_busy || dout_hold_q || tif.pulse;

    // Transmitter drives only in active mode and not after a dominant timeout.
    wire tx_ok = in_active && !txd_blocked;
    wire tx_d = tx_ok ? txd_in : 1'b1;
    wire rx_d = (in_active || in_rx_only) ? bus_rx_in : !rxd_low_q;

    // Cyclic timer runs only in stop with a non-zero period.
    assign tif.run = cyc_on;
    assign tif.period = cyc_period;

    // Read multiplexer; unmapped addresses read zero, except 0x84 to 0x90, which alias the four configuration sets.
    wire [4:0] cfg_ix = 5'(addr[7:2] - 6'h01);
    wire cfg_hit = (addr[1:0] == 2'h0) && (cfg_ix < 5'h04) && (addr >= ADDR_CFG_BASE);
    always_comb begin
        rd_mux = 16'h0000;
        if (addr == ADDR_CTRL) begin
            rd_mux = {wd_keep_q, meas_on_q, 11'h000, 3'(mode_q)};
        end else if (addr == ADDR_STATUS) begin
            rd_mux = {8'h00, txd_blocked, watchdog_en, dout_hold_q, mon_flag_q,
                      bus_flag_q, 3'(mode_q)};
        end else if (cfg_hit) begin
            rd_mux = {7'h00, cfg_q[cfg_ix[1:0]]};
        end
    end

    // Mode register and the measurement and watchdog keep-on bits written through the control word.
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_q <= M_STANDBY;
            meas_on_q <= 1'b0;
            wd_keep_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (wr_ctrl) begin
                meas_on_q <= wdata[BIT_MEAS_ON];
                wd_keep_q <= watchdog_keep_on_bit;
            end
        end
    end

    // One storage word per configuration set, addressed by the selection bits.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cfg
            always_ff @(posedge clock) begin
                if (rst) begin
                    cfg_q[gi] <= CFG_RST;
                end else if (wr_ctrl && (cfg_sel == 2'(gi))) begin
                    cfg_q[gi] <= cfg_field;
                end
            end
        end
    endgenerate

    // Watchdog keep-on is frozen when a power-saving mode is entered.
    always_ff @(posedge clock) begin
        if (rst) begin
            wd_keep_stop_q <= 1'b0;
            wd_off_q <= 1'b0;
        end else begin
            if (enter_saving) begin
                wd_keep_stop_q <= watchdog_keep_on_bit;
            end
            wd_off_q <= in_stop && (mode_d == M_STOP) && (wd_off_q || wd_off_set);
        end
    end

    // Previous monitor input levels for change detection.
    always_ff @(posedge clock) begin
        if (rst) begin
            mon_prev_q <= '0;
        end else begin
            mon_prev_q <= monitor_wake_inputs;
        end
    end

    // Wake indications; a set in the same cycle as its clear wins.
    always_ff @(posedge clock) begin
        if (rst) begin
            rxd_low_q <= 1'b0;
            dout_hold_q <= 1'b0;
            bus_flag_q <= 1'b0;
            mon_flag_q <= 1'b0;
        end else begin
            rxd_low_q <= saving_bus_wake || (rxd_low_q && !mode_wr);
            dout_hold_q <= hold_set || (dout_hold_q && !wr_ctrl);
            bus_flag_q <= saving_bus_wake || (bus_flag_q && !wr_ctrl);
            mon_flag_q <= (stop_mon_wake || (in_sleep && mon_evt)) || (mon_flag_q && !wr_ctrl);
        end
    end

    // Two internal cycle notification counter, in clocks.
    always_ff @(posedge clock) begin
        if (rst) begin
            note_cnt_q <= 16'h0000;
        end else if (note_load) begin
            note_cnt_q <= NOTE_CLKS;
        end else if (note_busy) begin
            note_cnt_q <= 16'(note_cnt_q - 16'h0001);
        end
    end

    // Registered outputs toward pins and analog blocks.
    always_ff @(posedge clock) begin
        if (rst) begin
            serial_dout <= 1'b1;
            rxd_out <= 1'b1;
            bus_tx_out <= 1'b1;
            transceiver_en <= 1'b0;
            termination_en <= 1'b0;
            core_supply_regulator_en <= 1'b1;
            slow_slope_en <= 1'b0;
            meas_en <= 1'b0;
            meas_channel_sel <= 1'b0;
            converter_reference_output <= 1'b0;
            watchdog_en <= 1'b1;
            watchdog_long_open <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            serial_dout <= !dout_low;
            rxd_out <= rx_d;
            bus_tx_out <= tx_d;
            transceiver_en <= in_active || in_rx_only;
            termination_en <= in_active || in_rx_only;
            core_supply_regulator_en <= !in_sleep;
            slow_slope_en <= gen_cfg[GEN_SLOW];
            meas_en <= meas_on_q && in_active;
            meas_channel_sel <= gen_cfg[GEN_MEAS_CH];
            converter_reference_output <= in_active;
            watchdog_en <= wd_on_now;
            watchdog_long_open <= long_open_d;
            rdata <= rd_en ? rd_mux : 16'h0000;
        end
    end

    // Cyclic wake pulse generator.
    cyclic_wake_timer #(
        .CYCLE_CLKS(CYCLE_CLKS)
    ) u_timer (
        .clock(clock),
        .rst(rst),
        .tif(tif.timer)
    );

    // Dominant timeout guard on the transmit input.
    txd_dominant_guard #(
        .TO_CLKS(TO_CLKS),
        .REC_CLKS(REC_CLKS),
        .CW(24)
    ) u_txd_guard (
        .clock(clock),
        .rst(rst),
        .txd_in(txd_in),
        .blocked(txd_blocked)
    );
endmodule // stop_mode_wake_signalling
`default_nettype wire

// ==== tb/wake_host_model.sv ====
// Host interrupt input model that times the wake notifications on the data-out line.
`default_nettype none
module wake_host_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic host_wake_irq_input,
    output logic [7:0] notes_q,
    output logic [7:0] low_len_q,
    output logic [7:0] gap_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic irq_q;
    logic fall;
    logic [7:0] low_cnt_q;
    logic [7:0] gap_cnt_q;
    // A falling edge is one notification to the host.
    assign fall = irq_q && !host_wake_irq_input;
    // The input is edge sensitive; it counts edges, low spans and the spacing of edges.
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b1;
            notes_q <= 8'h00;
            low_len_q <= 8'h00;
            gap_q <= 8'h00;
            low_cnt_q <= 8'h00;
            gap_cnt_q <= 8'h00;
        end else begin
            irq_q <= host_wake_irq_input;
            low_cnt_q <= host_wake_irq_input ? 8'h00 : low_cnt_q + 8'h01;
            gap_cnt_q <= fall ? 8'h01 : gap_cnt_q + 8'h01;
            if (fall) begin
                notes_q <= notes_q + 8'h01;
                gap_q <= gap_cnt_q;
            end
            if (!irq_q && host_wake_irq_input) begin
                low_len_q <= low_cnt_q;
            end
        end
    end
endmodule // wake_host_model
`default_nettype wire

// ==== tb/stop_mode_wake_signalling_props.sv ====
// Port-level assertions of the stop-mode wake signalling block.
`default_nettype none
module wake_sig_props
    import sbc_wake_pkg::*;
#(
    parameter int CYCLE_CLKS = 2,
    parameter int TO_CLKS = 20
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic bus_wake,
    input wire logic ldo_load_low,
    input wire logic txd_in,
    input wire logic serial_dout,
    input wire logic rxd_out,
    input wire logic bus_tx_out,
    input wire logic transceiver_en,
    input wire logic termination_en,
    input wire logic core_supply_regulator_en,
    input wire logic meas_channel_sel,
    input wire logic converter_reference_output,
    input wire logic watchdog_en,
    input wire logic watchdog_long_open
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ctrl_wr;
    logic code_ok;
    logic stop_q;
    logic keep_q;
    logic [3:0] gap_q;
    logic [15:0] low_q;
    logic [31:0] txl_q;
    // Control writes and the selectable mode codes.
    assign ctrl_wr = wr_en && (addr == ADDR_CTRL);
    assign code_ok = wdata[1] || (wdata[2:0] == 3'h4);
    // Tracks stop mode, the latched keep bit, distance from writes and low run lengths.
    always_ff @(posedge clock) begin
        if (rst) begin
            stop_q <= 1'b0;
            keep_q <= 1'b0;
            gap_q <= 4'h0;
            low_q <= 16'h0000;
            txl_q <= 32'h0000_0000;
        end else begin
            if (ctrl_wr && code_ok) begin
                stop_q <= (wdata[2:0] == 3'h7);
            end
            if (ctrl_wr && code_ok && !stop_q) begin
                keep_q <= wdata[15];
            end
            gap_q <= ctrl_wr ? 4'h0 : ((gap_q == 4'hF) ? gap_q : gap_q + 4'h1);
            low_q <= serial_dout ? 16'h0000 : low_q + 16'h0001;
            txl_q <= txd_in ? 32'h0000_0000 : txl_q + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_stop_supply: assert property (ctrl_wr && wdata[2:0] == 3'h7 |-> ##2
        !transceiver_en && !termination_en && core_supply_regulator_en)
        else $error("stop entry supply state wrong");
    a_active_xcvr: assert property (ctrl_wr && wdata[2:0] == 3'h3 |-> ##2
        transceiver_en && converter_reference_output)
        else $error("active mode transceiver off");
    a_bus_note: assert property (stop_q && bus_wake && !ctrl_wr ##1 !ctrl_wr |-> ##1
        !serial_dout && !rxd_out)
        else $error("bus wake not signalled");
    a_rxd_hold: assert property (stop_q && $past(stop_q) && !rxd_out && !ctrl_wr
        |=> !rxd_out) else $error("receive low released early");
    a_note_length: assert property ($rose(serial_dout) && stop_q && gap_q > 4'h4
        |-> low_q == 2 * CYCLE_CLKS) else $error("wake pulse length wrong");
    a_wd_low_load: assert property (stop_q && ldo_load_low && !keep_q
        |-> ##[1:3] !watchdog_en) else $error("watchdog kept on at low load");
    a_wd_keep_on: assert property (stop_q && $past(stop_q, 2) && keep_q
        |-> watchdog_en) else $error("kept watchdog switched off");
    a_exit_open: assert property ($fell(stop_q) && !$past(watchdog_en)
        |-> watchdog_long_open) else $error("no long open window");
    a_txd_cut: assert property (txl_q > TO_CLKS + 3 |-> bus_tx_out)
        else $error("long dominant not released");
    a_meas_chan: assert property (ctrl_wr && wdata[4:3] == 2'h0 |-> ##2
        meas_channel_sel == $past(wdata[13], 2)) else $error("channel select wrong");
endmodule // wake_sig_props

bind stop_mode_wake_signalling wake_sig_props #(.CYCLE_CLKS(CYCLE_CLKS), .TO_CLKS(TO_CLKS))
    u_props (.clock, .rst, .addr, .wdata, .wr_en, .bus_wake, .ldo_load_low, .txd_in,
    .serial_dout, .rxd_out, .bus_tx_out, .transceiver_en, .termination_en,
    .core_supply_regulator_en, .meas_channel_sel, .converter_reference_output,
    .watchdog_en, .watchdog_long_open);
`default_nettype wire

// ==== tb/stop_mode_wake_signalling_bench.sv ====
// Self-checking bench of the stop-mode wake signalling block.
`default_nettype none
module stop_mode_wake_signalling_bench
    import sbc_wake_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CY = 2;
    localparam int TO = 20;
    localparam int RC = 5;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic bus_wake = 1'b0;
    logic [4:0] monitor_wake_inputs = 5'h00;
    logic ldo_load_low = 1'b0;
    logic txd_in = 1'b1;
    logic bus_rx_in = 1'b1;
    logic [15:0] rdata, rv;
    logic serial_dout, rxd_out, bus_tx_out, transceiver_en, termination_en;
    logic core_supply_regulator_en, slow_slope_en, meas_en, meas_channel_sel;
    logic converter_reference_output, watchdog_en, watchdog_long_open;
    logic [7:0] notes, low_len, gap, n0;
    logic [2:0] codes [8] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h0, 3'h1, 3'h5};
    logic [2:0] modes [8] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
    logic [7:0] xcv_map = 8'h0A;
    int n_errors = 0;
    int total_checks = 0;
    int long_opens = 0;
    int lo0;
    // Clock of 10 ns period.
    initial forever #5 clock = ~clock;
    stop_mode_wake_signalling #(.CYCLE_CLKS(CY), .TO_CLKS(TO), .REC_CLKS(RC)) u_dut (
        .clock, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .bus_wake, .monitor_wake_inputs,
        .ldo_load_low, .txd_in, .bus_rx_in, .serial_dout, .rxd_out, .bus_tx_out,
        .transceiver_en, .termination_en, .core_supply_regulator_en, .slow_slope_en, .meas_en,
        .meas_channel_sel, .converter_reference_output, .watchdog_en, .watchdog_long_open);
    wake_host_model u_host (.clock, .rst, .host_wake_irq_input(serial_dout),
        .notes_q(notes), .low_len_q(low_len), .gap_q(gap));
    // Counts the one-cycle long open window requests.
    always @(posedge clock) begin
        if (watchdog_long_open === 1'b1) begin
            long_opens <= long_opens + 1;
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clock);
        addr <= ADDR_CTRL;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        rv = rdata;
    endtask
    task automatic kick();
        @(posedge clock);
        bus_wake <= 1'b1;
        @(posedge clock);
        bus_wake <= 1'b0;
    endtask
    task automatic tx(input logic v);
        @(posedge clock);
        txd_in <= v;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #50000;
        n_errors++;
        wrap_up();
    end
    // Main test sequence.
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        cyc(2);
        chk("dout_idle", serial_dout, 16'h1);
        rd(8'h20);
        chk("unmapped", rv, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr({13'h0000, codes[i]});
            cyc(3);
            chk("xcvr", transceiver_en, xcv_map[i]);
            rd(ADDR_CTRL);
            chk("mode", rv & 16'h0007, modes[i]);
        end
        wr(16'h0003);
        wr(16'h0107);
        cyc(3);
        chk("term", termination_en, 16'h0);
        chk("supply", core_supply_regulator_en, 16'h1);
        @(posedge clock);
        ldo_load_low <= 1'b1;
        cyc(4);
        chk("wd_off", watchdog_en, 16'h0);
        n0 = notes;
        kick();
        cyc(8);
        chk("rxd_low", rxd_out, 16'h0);
        chk("note_len", low_len, 2 * CY);
        @(posedge clock);
        monitor_wake_inputs <= 5'h02;
        cyc(8);
        @(posedge clock);
        monitor_wake_inputs <= 5'h03;
        cyc(8);
        chk("notes", notes - n0, 16'h2);
        lo0 = long_opens;
        wr(16'h0003);
        cyc(4);
        chk("open", long_opens - lo0, 16'h1);
        chk("rxd_back", rxd_out, 16'h1);
        tx(1'b0);
        cyc(4);
        chk("tx_dom", bus_tx_out, 16'h0);
        cyc(TO);
        chk("tx_cut", bus_tx_out, 16'h1);
        tx(1'b1);
        cyc(2);
        tx(1'b0);
        cyc(2);
        chk("tx_held", bus_tx_out, 16'h1);
        tx(1'b1);
        cyc(RC + 4);
        tx(1'b0);
        cyc(3);
        chk("tx_free", bus_tx_out, 16'h0);
        tx(1'b1);
        wr(16'h6083);
        cyc(3);
        chk("slow", slow_slope_en, 16'h1);
        chk("ch_temp", meas_channel_sel, 16'h1);
        chk("meas", meas_en, 16'h1);
        chk("vref", converter_reference_output, 16'h1);
        wr(16'h0003);
        cyc(3);
        chk("ch_bat", meas_channel_sel, 16'h0);
        lo0 = long_opens;
        wr(16'h8007);
        cyc(6);
        chk("wd_keep", watchdog_en, 16'h1);
        wr(16'h0003);
        cyc(4);
        chk("no_open", long_opens - lo0, 16'h0);
        n0 = notes;
        wr(16'h00B7);
        cyc(35);
        chk("cyc_n", notes - n0, 16'h3);
        chk("cyc_gap", gap, 5 * CY);
        chk("cyc_len", low_len, 2 * CY);
        rd(ADDR_CFG_BASE + 8'h08);
        chk("cyc_cfg", rv, 16'h0005);
        kick();
        cyc(30);
        chk("hold", serial_dout, 16'h0);
        lo0 = long_opens;
        wr(16'h0003);
        cyc(4);
        chk("released", serial_dout, 16'h1);
        chk("cyc_open", long_opens - lo0, 16'h1);
        wr(16'h0004);
        cyc(3);
        chk("reg_off", core_supply_regulator_en, 16'h0);
        kick();
        cyc(4);
        chk("rxd_w", rxd_out, 16'h0);
        chk("dout_w", serial_dout, 16'h0);
        rd(ADDR_STATUS);
        chk("standby", rv & 16'h0007, 16'h0000);
        chk("flags", rv & 16'h0038, 16'h0028);
        wrap_up();
    end
endmodule // stop_mode_wake_signalling_bench
`default_nettype wire
